// ### inc/gamlut_pkg.sv
// gamlut_pkg: widths, counts, reset values and types of the gamma table mapper.
// assumes one system clock; imported by every gamlut module except gamlut_delay.
package gamlut_pkg;

  // sample width and plane count fixed for this build
  localparam int unsigned PIX_W = 8;
  localparam int unsigned PLANES = 3;
  localparam int unsigned PLANE_W = 2;
  localparam int unsigned DEPTH = 1 << PIX_W;

  // output latency in clock cycles, input edge to output visible
  localparam int unsigned LATENCY = 5;
  // bypass data delay so it lines up with the table read result
  localparam int unsigned BYP_DLY = 2;

  // control word carried beside the data: valid, correct, plane
  localparam int unsigned CTRL_W = 2 + PLANE_W;
  localparam int unsigned CTRL_VALID_POS = PLANE_W + 1;
  localparam int unsigned CTRL_CORR_POS = PLANE_W;

  // one table serves all planes when every curve is identical
  localparam bit SHARE_CURVES = 1'b0;

  typedef logic [PIX_W-1:0] gamlut_pix_t;
  typedef logic [PLANE_W-1:0] gamlut_plane_t;
  typedef logic [CTRL_W-1:0] gamlut_ctrl_t;

  localparam gamlut_pix_t PIX_RST = 8'h00;
  localparam gamlut_plane_t PLANE_RST = 2'h0;
  localparam gamlut_ctrl_t CTRL_RST = 4'h0;

  typedef enum logic {
    GAMLUT_PARALLEL,
    GAMLUT_SEQUENTIAL
  } gamlut_mode_e;

endpackage : gamlut_pkg

// ### rtl/gamlut_table.sv
// gamlut_table: one correction table in flip-flops, one write port,
// N_RD registered read ports. assumes writes and reads share clk_in.
`timescale 1ns/1ns
module gamlut_table #(
  parameter int unsigned N_RD = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic step_gate_in,
  input wire logic sync_clear_in,
  input wire logic wr_en_in,
  input wire gamlut_pkg::gamlut_pix_t wr_addr_in,
  input wire gamlut_pkg::gamlut_pix_t wr_data_in,
  input wire gamlut_pkg::gamlut_pix_t rd_addr_in [N_RD],
  output gamlut_pkg::gamlut_pix_t rd_data_out [N_RD]
);
  import gamlut_pkg::*;

  gamlut_pix_t mem_q [DEPTH];
  gamlut_pix_t rd_q [N_RD];

  // 2^b entries of b bits; reset loads an identity curve so bypass-like
  // behaviour holds until software loads a real curve
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= gamlut_pix_t'(i);
    end
    else if (step_gate_in && wr_en_in)
      mem_q[wr_addr_in] <= wr_data_in;
  end

  // registered read, one stage of the fixed latency
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int r = 0; r < N_RD; r++)
        rd_q[r] <= PIX_RST;
    end
    else if (step_gate_in)
    begin
      for (int r = 0; r < N_RD; r++)
        rd_q[r] <= sync_clear_in ? PIX_RST : mem_q[rd_addr_in[r]];
    end
  end

  assign rd_data_out = rd_q;

endmodule : gamlut_table

// ### rtl/gamlut_delay.sv
// gamlut_delay: fixed-depth shift pipe with hold and synchronous clear.
// assumes D is at least 1.
`timescale 1ns/1ns
module gamlut_delay #(
  parameter int unsigned W = 1,
  parameter int unsigned D = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic step_gate_in,
  input wire logic sync_clear_in,
  input wire logic [W-1:0] data_in,
  output logic [W-1:0] data_out
);

  logic [W-1:0] stage_q [D];

  // shift only while the gate is open; clear empties every stage
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < D; i++)
        stage_q[i] <= '0;
    end
    else if (step_gate_in)
    begin
      for (int i = 0; i < D; i++)
        stage_q[i] <= sync_clear_in ? '0 : ((i == 0) ? data_in : stage_q[(i == 0) ? 0 : i - 1]);
    end
  end

  assign data_out = stage_q[D-1];

endmodule : gamlut_delay

// ### rtl/gamlut_mapper.sv
// gamlut_mapper: gamma table pixel mapper, parallel or sequential planes.
// assumes upstream logic drives inputs synchronous to clk_in and does not
// expect corrected samples while it is reloading a table.
//
// Functional notes
// - each table holds 2^b entries of b bits, one per input value
// - reload writes one entry per clock; full reload takes table-depth clocks
// - plane index presented with a sample chooses its table
// - sequential mode maps one component per clock
// - parallel mode maps all planes in one clock on separate ports
// - table x written at pixel input x address with its value and strobe
// - sequential mode loads all tables via first port, plane index selects
// - bypassed samples pass unchanged after the same latency
// - plane index output follows the sample on the output ports
// - asynchronous active-low clear resets the whole block
// - first port carries all planes sequentially, only first plane in parallel
// - result valid marks output data, corrected or bypassed
// - correct request sampled only with sample valid
// - corrected flag is correct request delayed by the output latency
// - second and third plane ports exist for more than one or two planes
// - first table value and strobe exist when first curve is programmable
// - planes with identical curves share one physical table
// - output latency fixed, between four and six clocks
// - narrower sequential planes are left aligned with zero low bits
// - while step gate low, inputs ignored and all state held
// - sync clear empties all pipeline registers and drops result valid
`timescale 1ns/1ns
module gamlut_mapper (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic step_gate_in,
  input wire logic sync_clear_in,
  input wire gamlut_pkg::gamlut_mode_e arch_mode_in,
  input wire logic sample_valid_in,
  input wire logic correct_request_in,
  input wire gamlut_pkg::gamlut_plane_t plane_index_in,
  input wire gamlut_pkg::gamlut_pix_t pixel_in_first_in,
  input wire gamlut_pkg::gamlut_pix_t pixel_in_second_in,
  input wire gamlut_pkg::gamlut_pix_t pixel_in_third_in,
  input wire gamlut_pkg::gamlut_pix_t first_table_value_in,
  input wire logic first_table_write_in,
  input wire gamlut_pkg::gamlut_pix_t second_table_value_in,
  input wire logic second_table_write_in,
  input wire gamlut_pkg::gamlut_pix_t third_table_value_in,
  input wire logic third_table_write_in,
  output logic result_valid_out,
  output logic corrected_flag_out,
  output gamlut_pkg::gamlut_plane_t plane_index_out,
  output gamlut_pkg::gamlut_pix_t pixel_out_first_out,
  output gamlut_pkg::gamlut_pix_t pixel_out_second_out,
  output gamlut_pkg::gamlut_pix_t pixel_out_third_out
);
  import gamlut_pkg::*;

  // plane index to table number; unused index codes fall back to table 0
  function automatic int unsigned plane_to_table(input gamlut_plane_t plane);
    int unsigned t;
    t = 32'(plane);
    if (t >= PLANES)
      t = 0;
    return t;
  endfunction : plane_to_table

  logic seq_mode;
  gamlut_pix_t pix_in [PLANES];
  gamlut_pix_t tbl_val_in [PLANES];
  logic tbl_wr_in [PLANES];
  gamlut_pix_t in_pix_q [PLANES];
  gamlut_plane_t plane_s1_q;
  gamlut_plane_t plane_s2_q;
  logic corr_s1_q;
  logic corr_s2_q;
  logic corr_s3_q;
  gamlut_pix_t byp_q [BYP_DLY][PLANES];
  gamlut_pix_t rd_addr [PLANES];
  gamlut_pix_t rd_pix [PLANES];
  gamlut_pix_t sel_q [PLANES];
  gamlut_pix_t mid_q [PLANES];
  gamlut_pix_t out_q [PLANES];
  gamlut_ctrl_t ctrl_in;
  gamlut_ctrl_t ctrl_out;

  assign seq_mode = (arch_mode_in == GAMLUT_SEQUENTIAL);

  // gather the per-plane ports; all three exist since three planes are built
  assign pix_in[0] = pixel_in_first_in;
  assign pix_in[1] = pixel_in_second_in;
  assign pix_in[2] = pixel_in_third_in;
  assign tbl_val_in[0] = first_table_value_in;
  assign tbl_val_in[1] = second_table_value_in;
  assign tbl_val_in[2] = third_table_value_in;
  assign tbl_wr_in[0] = first_table_write_in;
  assign tbl_wr_in[1] = second_table_write_in;
  assign tbl_wr_in[2] = third_table_write_in;

  // input capture stage; inputs are sampled only while the gate is open
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int k = 0; k < PLANES; k++)
        in_pix_q[k] <= PIX_RST;
    end
    else if (step_gate_in)
    begin
      for (int k = 0; k < PLANES; k++)
        in_pix_q[k] <= sync_clear_in ? PIX_RST : pix_in[k];
    end
  end

  // plane and correct request follow the data to the table select stage
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      plane_s1_q <= PLANE_RST;
      plane_s2_q <= PLANE_RST;
      corr_s1_q <= 1'b0;
      corr_s2_q <= 1'b0;
      corr_s3_q <= 1'b0;
    end
    else if (step_gate_in)
    begin
      if (sync_clear_in)
      begin
        plane_s1_q <= PLANE_RST;
        plane_s2_q <= PLANE_RST;
        corr_s1_q <= 1'b0;
        corr_s2_q <= 1'b0;
        corr_s3_q <= 1'b0;
      end
      else
      begin
        plane_s1_q <= plane_index_in;
        plane_s2_q <= plane_s1_q;
        corr_s1_q <= sample_valid_in && correct_request_in;
        corr_s2_q <= corr_s1_q;
        corr_s3_q <= corr_s2_q;
      end
    end
  end

  // bypass copy of the raw input, aligned with the table read result
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int s = 0; s < BYP_DLY; s++)
        for (int k = 0; k < PLANES; k++)
          byp_q[s][k] <= PIX_RST;
    end
    else if (step_gate_in)
    begin
      for (int s = 0; s < BYP_DLY; s++)
        for (int k = 0; k < PLANES; k++)
          byp_q[s][k] <= sync_clear_in ? PIX_RST : ((s == 0) ? in_pix_q[k]
                         : byp_q[(s == 0) ? 0 : s - 1][k]);
    end
  end

  // sequential mode looks every table up with the first port's sample;
  // the plane index picks the result later, which costs no extra reads
  always_comb
  begin
    for (int k = 0; k < PLANES; k++)
      rd_addr[k] = seq_mode ? in_pix_q[0] : in_pix_q[k];
  end

  // table instances: shared or one per plane, fixed at build time
  generate
    if (SHARE_CURVES)
    begin : g_shared
      logic wr_en;
      // one curve: sequential loads take any plane, parallel loads the first
      assign wr_en = first_table_write_in;
      gamlut_table #(.N_RD(PLANES)) u_table (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .step_gate_in(step_gate_in),
        .sync_clear_in(sync_clear_in),
        .wr_en_in(wr_en),
        .wr_addr_in(pixel_in_first_in),
        .wr_data_in(first_table_value_in),
        .rd_addr_in(rd_addr),
        .rd_data_out(rd_pix)
      );
    end
    else
    begin : g_split
      for (genvar k = 0; k < PLANES; k++)
      begin : g_plane
        logic wr_en;
        gamlut_pix_t wr_addr;
        gamlut_pix_t wr_data;
        gamlut_pix_t addr_one [1];
        gamlut_pix_t data_one [1];
        // sequential writes steer through the first port by plane index
        assign wr_en = seq_mode ? (first_table_write_in
                       && (plane_to_table(plane_index_in) == k)) : tbl_wr_in[k];
        assign wr_addr = seq_mode ? pixel_in_first_in : pix_in[k];
        assign wr_data = seq_mode ? first_table_value_in : tbl_val_in[k];
        assign addr_one[0] = rd_addr[k];
        assign rd_pix[k] = data_one[0];
        gamlut_table #(.N_RD(1)) u_table (
          .clk_in(clk_in),
          .rst_b_in(rst_b_in),
          .step_gate_in(step_gate_in),
          .sync_clear_in(sync_clear_in),
          .wr_en_in(wr_en),
          .wr_addr_in(wr_addr),
          .wr_data_in(wr_data),
          .rd_addr_in(addr_one),
          .rd_data_out(data_one)
        );
      end
    end
  endgenerate

  // table select stage; in sequential mode the sample's plane index chooses the first port's curve
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int k = 0; k < PLANES; k++)
        sel_q[k] <= PIX_RST;
    end
    else if (step_gate_in)
    begin
      for (int k = 0; k < PLANES; k++)
        if (sync_clear_in)
          sel_q[k] <= PIX_RST;
        else if (k == 0 && seq_mode)
          sel_q[k] <= rd_pix[plane_to_table(plane_s2_q)];
        else
          sel_q[k] <= rd_pix[k];
    end
  end

  // corrected or bypassed value per sample
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int k = 0; k < PLANES; k++)
        mid_q[k] <= PIX_RST;
    end
    else if (step_gate_in)
    begin
      for (int k = 0; k < PLANES; k++)
        mid_q[k] <= sync_clear_in ? PIX_RST
                    : (corr_s3_q ? sel_q[k] : byp_q[BYP_DLY-1][k]);
    end
  end

  // output registers; equal widths keep sequential data left aligned as is
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int k = 0; k < PLANES; k++)
        out_q[k] <= PIX_RST;
    end
    else if (step_gate_in)
    begin
      for (int k = 0; k < PLANES; k++)
        out_q[k] <= sync_clear_in ? PIX_RST : mid_q[k];
    end
  end

  // control travels on its own pipe of the full latency
  assign ctrl_in = {sample_valid_in, sample_valid_in && correct_request_in, plane_index_in};

  gamlut_delay #(.W(CTRL_W), .D(LATENCY)) u_ctrl_pipe (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .step_gate_in(step_gate_in),
    .sync_clear_in(sync_clear_in),
    .data_in(ctrl_in),
    .data_out(ctrl_out)
  );

  assign result_valid_out = ctrl_out[CTRL_VALID_POS];
  assign corrected_flag_out = ctrl_out[CTRL_CORR_POS];
  assign plane_index_out = ctrl_out[PLANE_W-1:0];
  assign pixel_out_first_out = out_q[0];
  assign pixel_out_second_out = out_q[1];
  assign pixel_out_third_out = out_q[2];

  // checks: pipeline advances only out of reset, gate open and no clear;
  // the edge that releases reset still loads reset values, so it is excluded
  logic run;
  assign run = rst_b_in && step_gate_in && !sync_clear_in;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_valid_latency: assert property (
    (sample_valid_in && run) ##1 run [*4] |-> ##1 result_valid_out)
    else $error("accepted sample gave no result valid after latency");

  a_no_spurious_valid: assert property (
    (!sample_valid_in && run) ##1 run [*4] |-> ##1 !result_valid_out)
    else $error("result valid without an accepted sample");

  a_flag_latency: assert property (
    (sample_valid_in && run) ##1 run [*4]
    |-> ##1 (corrected_flag_out == $past(correct_request_in, 5)))
    else $error("corrected flag not aligned with correct request");

  a_plane_follows: assert property (
    run ##1 run [*4] |-> ##1 (plane_index_out == $past(plane_index_in, 5)))
    else $error("plane index output does not follow its sample");

  a_bypass_first: assert property (
    (sample_valid_in && !correct_request_in && run) ##1 run [*4]
    |-> ##1 (pixel_out_first_out == $past(pixel_in_first_in, 5)))
    else $error("bypassed first sample changed or late");

  a_bypass_third: assert property (
    (sample_valid_in && !correct_request_in && run) ##1 run [*4]
    |-> ##1 (pixel_out_third_out == $past(pixel_in_third_in, 5)))
    else $error("bypassed third plane sample changed or late");

  a_gate_hold: assert property (
    !step_gate_in |=> $stable(result_valid_out) && $stable(pixel_out_first_out)
    && $stable(plane_index_out) && $stable(corrected_flag_out))
    else $error("state moved while step gate low");

  a_clear_drops: assert property (
    (step_gate_in && sync_clear_in) |=> !result_valid_out && !corrected_flag_out
    && (pixel_out_first_out == PIX_RST))
    else $error("sync clear left output valid or data");

  c_corrected_out: cover property (result_valid_out && corrected_flag_out);
  c_bypassed_out: cover property (result_valid_out && !corrected_flag_out);
  c_seq_third_plane: cover property (seq_mode && result_valid_out && plane_index_out == 2'h2);
  c_table_write: cover property (run && first_table_write_in ##1 run && sample_valid_in);

endmodule : gamlut_mapper

// ### test/gamlut_src_model.sv
// gamlut_src_model: upstream pixel source, drives samples and table writes.
// assumes the bench calls one task at a time; sample and load take one clock edge, idle takes n.
`timescale 1ns/1ns
module gamlut_src_model (
  input wire logic clk_in,
  output logic sample_valid_out,
  output logic correct_request_out,
  output gamlut_pkg::gamlut_plane_t plane_index_out,
  output gamlut_pkg::gamlut_pix_t pix_out [3],
  output gamlut_pkg::gamlut_pix_t value_out [3],
  output logic [2:0] write_out
);
  import gamlut_pkg::*;

  // quiet start so the mapper sees known levels from time zero
  initial
  begin
    sample_valid_out = 1'b0;
    correct_request_out = 1'b0;
    plane_index_out = PLANE_RST;
    write_out = 3'h0;
    for (int k = 0; k < 3; k++)
    begin
      pix_out[k] = PIX_RST;
      value_out[k] = PIX_RST;
    end
  end

  // one sample; full width samples, so left alignment is trivial
  task automatic sample(input logic v, input logic c, input gamlut_plane_t pl,
    input gamlut_pix_t d0, input gamlut_pix_t d1, input gamlut_pix_t d2);
    @(posedge clk_in);
    sample_valid_out <= v;
    correct_request_out <= c;
    plane_index_out <= pl;
    pix_out[0] <= d0;
    pix_out[1] <= d1;
    pix_out[2] <= d2;
    write_out <= 3'h0;
  endtask : sample

  // one table write per clock; never mixed with a sample
  task automatic load(input logic [2:0] we, input gamlut_plane_t pl, input gamlut_pix_t a,
    input gamlut_pix_t v0, input gamlut_pix_t v1, input gamlut_pix_t v2);
    @(posedge clk_in);
    sample_valid_out <= 1'b0;
    write_out <= we;
    plane_index_out <= pl;
    for (int k = 0; k < 3; k++)
    begin
      pix_out[k] <= a;
    end
    value_out[0] <= v0;
    value_out[1] <= v1;
    value_out[2] <= v2;
  endtask : load

  // idle cycles: released lines toggle so stale data never looks valid
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      sample_valid_out <= 1'b0;
      write_out <= 3'h0;
      correct_request_out <= ~correct_request_out;
      plane_index_out <= ~plane_index_out;
      for (int k = 0; k < 3; k++)
      begin
        pix_out[k] <= ~pix_out[k];
        value_out[k] <= ~value_out[k];
      end
    end
  endtask : idle
endmodule : gamlut_src_model

// ### test/tb_top.sv
// tb_top: self-checking bench for the gamma table mapper.
// assumes gamlut_src_model drives the upstream side; outputs mirrored here.
`timescale 1ns/1ns
module tb_top;
  import gamlut_pkg::*;

  typedef struct packed {
    logic m;
    logic v;
    logic c;
    gamlut_plane_t pl;
    gamlut_pix_t d0;
    gamlut_pix_t d1;
    gamlut_pix_t d2;
  } gamlut_row_s;

  // ordinary cases: mode (1 = sequential), valid, correct, plane, samples
  localparam gamlut_row_s ROWS [10] = '{
    '{1'b1, 1'b1, 1'b1, 2'h1, 8'h00, 8'h00, 8'h00},
    '{1'b1, 1'b1, 1'b1, 2'h1, 8'hff, 8'h00, 8'h00},
    '{1'b1, 1'b1, 1'b1, 2'h3, 8'h80, 8'h00, 8'h00},
    '{1'b1, 1'b1, 1'b1, 2'h2, 8'h40, 8'h00, 8'h00},
    '{1'b1, 1'b1, 1'b0, 2'h1, 8'hff, 8'h00, 8'h00},
    '{1'b1, 1'b0, 1'b1, 2'h0, 8'h12, 8'h00, 8'h00},
    '{1'b1, 1'b1, 1'b1, 2'h0, 8'h80, 8'h00, 8'h00},
    '{1'b0, 1'b1, 1'b1, 2'h2, 8'hff, 8'h01, 8'h7e},
    '{1'b0, 1'b1, 1'b0, 2'h1, 8'h33, 8'hcc, 8'h00},
    '{1'b0, 1'b1, 1'b1, 2'h3, 8'h00, 8'hff, 8'ha5}
  };

  logic clk_in;
  logic rst_b_in;
  logic step_gate_in;
  logic sync_clear_in;
  gamlut_mode_e arch_mode;
  logic s_v;
  logic s_c;
  gamlut_plane_t s_pl;
  gamlut_pix_t s_px [3];
  gamlut_pix_t s_val [3];
  logic [2:0] s_we;
  logic result_valid;
  logic corrected_flag;
  gamlut_plane_t plane_out;
  gamlut_pix_t pix_out [3];
  gamlut_pix_t tbl [3][DEPTH];
  logic rv [8];
  logic rc [8];
  logic rm [8];
  gamlut_plane_t rp [8];
  gamlut_pix_t rd [8][3];
  gamlut_pix_t x;
  int w = 0;
  int t;
  int j;
  int n;
  int fails = 0;
  int checked = 0;
  bit mon_on = 1'b0;
  logic seen;
  gamlut_pix_t px_a;
  gamlut_pix_t px_b;
  gamlut_pix_t px_c;
  gamlut_pix_t tv_a;
  gamlut_pix_t tv_b;
  gamlut_pix_t tv_c;
  logic we_a;
  logic we_b;
  logic we_c;

  // flat copies of the source model's lanes for the mapper's ports
  assign {px_c, px_b, px_a} = {s_px[2], s_px[1], s_px[0]};
  assign {tv_c, tv_b, tv_a} = {s_val[2], s_val[1], s_val[0]};
  assign {we_c, we_b, we_a} = s_we;

  gamlut_src_model gamlut_src_model_i (
    .clk_in(clk_in),
    .sample_valid_out(s_v),
    .correct_request_out(s_c),
    .plane_index_out(s_pl),
    .pix_out(s_px),
    .value_out(s_val),
    .write_out(s_we)
  );

  gamlut_mapper gamlut_mapper_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .step_gate_in(step_gate_in),
    .sync_clear_in(sync_clear_in),
    .arch_mode_in(arch_mode),
    .sample_valid_in(s_v),
    .correct_request_in(s_c),
    .plane_index_in(s_pl),
    .pixel_in_first_in(px_a),
    .pixel_in_second_in(px_b),
    .pixel_in_third_in(px_c),
    .first_table_value_in(tv_a),
    .first_table_write_in(we_a),
    .second_table_value_in(tv_b),
    .second_table_write_in(we_b),
    .third_table_value_in(tv_c),
    .third_table_write_in(we_c),
    .result_valid_out(result_valid),
    .corrected_flag_out(corrected_flag),
    .plane_index_out(plane_out),
    .pixel_out_first_out(pix_out[0]),
    .pixel_out_second_out(pix_out[1]),
    .pixel_out_third_out(pix_out[2])
  );

  task automatic check(input logic [7:0] seen_v, input logic [7:0] want_v);
    checked++;
    if (seen_v !== want_v)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, seen_v, want_v);
    end
  endtask : check

  task automatic complete_run();
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // mirror of the pipe: expected output of every edge, plus table writes
  always @(posedge clk_in)
  begin
    t = (s_pl == 2'h3) ? 0 : int'(s_pl);
    if (!rst_b_in)
    begin
      for (int k = 0; k < 3 * DEPTH; k++)
        tbl[k / DEPTH][k % DEPTH] = gamlut_pix_t'(k % DEPTH);
      for (int k = 0; k < 8; k++)
        rv[k] = 1'b0;
    end
    else
    begin
      rv[w] = s_v && step_gate_in && !sync_clear_in;
      rc[w] = s_c;
      rp[w] = s_pl;
      rm[w] = arch_mode;
      for (int k = 0; k < 3; k++)
      begin
        j = (arch_mode == GAMLUT_SEQUENTIAL) ? t : k;
        rd[w][k] = (s_v && s_c) ? tbl[j][s_px[k]] : s_px[k];
        if (step_gate_in && s_we[k] && arch_mode == GAMLUT_PARALLEL)
          tbl[k][s_px[k]] = s_val[k];
      end
      if (step_gate_in && s_we[0] && arch_mode == GAMLUT_SEQUENTIAL)
        tbl[t][s_px[0]] = s_val[0];
    end
    w = (w + 1) % 8;
  end

  // outputs compared one latency after the edge that took the sample
  always @(negedge clk_in)
  begin
    j = (w + 8 - LATENCY) % 8;
    if (mon_on)
    begin
      check({7'h00, result_valid}, {7'h00, rv[j]});
      if (rv[j])
      begin
        check({7'h00, corrected_flag}, {7'h00, rc[j]});
        check({6'h00, plane_out}, {6'h00, rp[j]});
        check(pix_out[0], rd[j][0]);
        if (rm[j] == 1'b0)
        begin
          check(pix_out[1], rd[j][1]);
          check(pix_out[2], rd[j][2]);
        end
      end
    end
  end

  initial
  begin
    rst_b_in = 1'b0;
    step_gate_in = 1'b1;
    sync_clear_in = 1'b0;
    arch_mode = GAMLUT_PARALLEL;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    mon_on = 1'b1;
    // full reload of all tables, one entry per clock, then a full sweep
    for (int a = 0; a < DEPTH; a++)
    begin
      x = gamlut_pix_t'(a);
      gamlut_src_model_i.load(3'h7, 2'h0, x, ~x, x ^ 8'h5a, x + 8'h11);
    end
    for (int a = 0; a < DEPTH; a++)
    begin
      x = gamlut_pix_t'(a);
      gamlut_src_model_i.sample(1'b1, 1'b1, 2'h0, x, ~x, x ^ 8'h0f);
    end
    gamlut_src_model_i.idle(8);
    // closed gate for three edges stretches the latency by three
    mon_on = 1'b0;
    gamlut_src_model_i.sample(1'b1, 1'b1, 2'h0, 8'h10, 8'h00, 8'h00);
    fork
      gamlut_src_model_i.idle(1);
      @(posedge clk_in) step_gate_in <= 1'b0;
    join
    repeat (3) @(posedge clk_in);
    step_gate_in <= 1'b1;
    // n is the cycle index counted from the cycle the sample was driven in
    n = 4;
    repeat (20)
    begin
      @(negedge clk_in);
      if (result_valid === 1'b1)
        break;
      n++;
    end
    check(8'(n), 8'(LATENCY + 3));
    check(pix_out[0], 8'hef);
    if (n > 20)
      complete_run();
    // a sample in flight is dropped by the synchronous clear
    gamlut_src_model_i.idle(8);
    gamlut_src_model_i.sample(1'b1, 1'b0, 2'h1, 8'h22, 8'h00, 8'h00);
    fork
      gamlut_src_model_i.idle(1);
      @(posedge clk_in) sync_clear_in <= 1'b1;
    join
    @(posedge clk_in) sync_clear_in <= 1'b0;
    seen = 1'b0;
    repeat (8)
    begin
      @(negedge clk_in);
      seen = seen | result_valid;
    end
    check({7'h00, seen}, 8'h00);
    gamlut_src_model_i.idle(4);
    arch_mode <= GAMLUT_SEQUENTIAL;
    gamlut_src_model_i.idle(4);
    mon_on = 1'b1;
    // sequential reload through the first port; plane 3 lands in table 0
    gamlut_src_model_i.load(3'h1, 2'h1, 8'h00, 8'hc3, 8'h00, 8'h00);
    gamlut_src_model_i.load(3'h1, 2'h1, 8'hff, 8'h3c, 8'h00, 8'h00);
    gamlut_src_model_i.load(3'h1, 2'h3, 8'h80, 8'h77, 8'h00, 8'h00);
    foreach (ROWS[i])
    begin
      if (ROWS[i].m != arch_mode)
      begin
        gamlut_src_model_i.idle(6);
        arch_mode <= gamlut_mode_e'(ROWS[i].m);
        gamlut_src_model_i.idle(2);
      end
      gamlut_src_model_i.sample(ROWS[i].v, ROWS[i].c, ROWS[i].pl, ROWS[i].d0,
        ROWS[i].d1, ROWS[i].d2);
    end
    // reset in mid-stream: last row's result stands, outputs drop at once
    gamlut_src_model_i.idle(4);
    repeat (2) @(negedge clk_in);
    #2 rst_b_in = 1'b0;
    #1 check({7'h00, result_valid}, 8'h00);
    check(pix_out[0], 8'h00);
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    // tables came back as identity, so a corrected sample equals its input
    gamlut_src_model_i.sample(1'b1, 1'b1, 2'h2, 8'h5a, 8'ha5, 8'h3c);
    gamlut_src_model_i.idle(8);
    complete_run();
  end
endmodule : tb_top
